// >>> logic/sar_defs.vh
`ifndef SAR_DEFS_VH
`define SAR_DEFS_VH
`define SAR_RES_BITS 16
`define SAR_ZERO_EDGE 3'h5
`define SAR_LAST_EDGE 5'h15
`define SAR_CODE_MAX 16'hFFFF
`define SAR_CODE_MIN 16'h0000
`define SAR_CODE_RST 16'h0000
`define SAR_FIFO_WIDTH 16
`define SAR_FIFO_DEPTH 16
`define SAR_FIFO_AW 4
`define SAR_CONV_CYCLES 8'h10
`endif

// >>> logic/sar_fifo.v
`include "sar_defs.vh"
module sar_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    clk,
    sys_rst,
    in_valid,
    in_ready,
    in_data,
    out_valid,
    out_ready,
    out_data
);
    input wire clk;
    input wire sys_rst;
    input wire in_valid;
    output wire in_ready;
    input wire [WIDTH-1:0] in_data;
    output wire out_valid;
    input wire out_ready;
    output wire [WIDTH-1:0] out_data;

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_reg;
    reg [AW-1:0] rd_reg;
    reg [AW:0] cnt_reg;
    reg [AW:0] cnt_next;
    reg ready_reg;
    wire do_wr;
    wire do_rd;
    localparam [AW:0] FULL = DEPTH;

    // ready is registered so the top port comes straight from a flop
    assign in_ready = ready_reg;
    assign out_valid = (cnt_reg != {(AW+1){1'b0}});
    assign out_data = mem[rd_reg];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always @* begin
        cnt_next = cnt_reg;
        if (do_wr && !do_rd) begin
            cnt_next = cnt_reg + 1'b1;
        end else if (do_rd && !do_wr) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always @(posedge clk) begin
        if (do_wr) begin
            mem[wr_reg] <= in_data;
        end
        if (sys_rst) begin
            wr_reg <= {AW{1'b0}};
            rd_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
            ready_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_next;
            ready_reg <= (cnt_next != FULL);
            if (do_wr) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end
endmodule

// >>> logic/sar_readout.v
`include "sar_defs.vh"
// Behaviour
// - select fall starts conversion and transfer
// - fifth clock fall enables output, drives zero
// - then one bit per fall, msb first
// - bit held from fall to next fall
// - idle low-power after each conversion
// - new code presented right after conversion
// - code is the oldest sample buffered in the fifo, popped in this frame
// - overrange saturates to all ones
// - underrange saturates to all zeros, unless overrange is also set (then all ones)
module sar_readout (
    clk,
    sys_rst,
    select_n_in,
    serial_clock_in,
    sample_valid,
    sample_ready,
    sample_code,
    sample_over,
    sample_under,
    serial_data_out,
    serial_data_oe_n,
    converting,
    powered_down,
    frame_active
);
    input wire clk;
    input wire sys_rst;
    input wire select_n_in;
    input wire serial_clock_in;
    input wire sample_valid;
    output wire sample_ready;
    input wire [15:0] sample_code;
    input wire sample_over;
    input wire sample_under;
    output reg serial_data_out;
    output reg serial_data_oe_n;
    output reg converting;
    output reg powered_down;
    output reg frame_active;

    localparam ST_IDLE = 3'b001;
    localparam ST_CONV = 3'b010;
    localparam ST_DONE = 3'b100;

    reg sel_s1_reg;
    reg sel_s2_reg;
    reg sel_s3_reg;
    reg sck_s1_reg;
    reg sck_s2_reg;
    reg sck_s3_reg;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [7:0] conv_cnt_reg;
    reg [4:0] edge_cnt_reg;
    reg [15:0] shift_reg;
    reg have_code_reg;
    reg fifo_pop_reg;
    reg [15:0] code_sat;
    wire sel_fall;
    wire sel_rise;
    wire sck_fall;
    wire fifo_valid;
    wire [15:0] fifo_data;
    wire fifo_in_ready;

    // sample stream is buffered; a full fifo stalls the analog front end
    sar_fifo #(
        .WIDTH(`SAR_FIFO_WIDTH),
        .DEPTH(`SAR_FIFO_DEPTH),
        .AW(`SAR_FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(sample_valid),
        .in_ready(fifo_in_ready),
        .in_data(code_sat),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop_reg),
        .out_data(fifo_data)
    );
    assign sample_ready = fifo_in_ready;

    always @* begin
        code_sat = sample_code;
        if (sample_over) begin
            code_sat = `SAR_CODE_MAX;
        end else if (sample_under) begin
            code_sat = `SAR_CODE_MIN;
        end
    end

    // only second stage and later feed edge logic
    assign sel_fall = sel_s3_reg && !sel_s2_reg;
    assign sel_rise = !sel_s3_reg && sel_s2_reg;
    assign sck_fall = sck_s3_reg && !sck_s2_reg;

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (sel_fall) begin
                    state_next = ST_CONV;
                end
            end
            ST_CONV: begin
                if (sel_rise) begin
                    state_next = ST_IDLE;
                end else if (conv_cnt_reg == `SAR_CONV_CYCLES && have_code_reg) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                if (sel_rise) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            sel_s1_reg <= 1'b1;
            sel_s2_reg <= 1'b1;
            sel_s3_reg <= 1'b1;
            sck_s1_reg <= 1'b0;
            sck_s2_reg <= 1'b0;
            sck_s3_reg <= 1'b0;
            state_reg <= ST_IDLE;
            conv_cnt_reg <= 8'h00;
            edge_cnt_reg <= 5'h00;
            shift_reg <= `SAR_CODE_RST;
            have_code_reg <= 1'b0;
            fifo_pop_reg <= 1'b0;
            serial_data_out <= 1'b0;
            serial_data_oe_n <= 1'b1;
            converting <= 1'b0;
            powered_down <= 1'b1;
            frame_active <= 1'b0;
        end else begin
            sel_s1_reg <= select_n_in;
            sel_s2_reg <= sel_s1_reg;
            sel_s3_reg <= sel_s2_reg;
            sck_s1_reg <= serial_clock_in;
            sck_s2_reg <= sck_s1_reg;
            sck_s3_reg <= sck_s2_reg;
            state_reg <= state_next;
            fifo_pop_reg <= 1'b0;
            converting <= (state_next == ST_CONV);
            powered_down <= (state_next != ST_CONV);
            frame_active <= (state_next != ST_IDLE);
            if (state_reg == ST_IDLE && sel_fall) begin
                conv_cnt_reg <= 8'h00;
                edge_cnt_reg <= 5'h00;
                have_code_reg <= 1'b0;
            end else if (state_reg == ST_CONV && conv_cnt_reg != `SAR_CONV_CYCLES) begin
                conv_cnt_reg <= conv_cnt_reg + 8'h01;
            end
            // code taken after the select fall belongs to this frame only
            if (state_reg == ST_CONV && !have_code_reg && fifo_valid && !fifo_pop_reg) begin
                shift_reg <= fifo_data;
                have_code_reg <= 1'b1;
                fifo_pop_reg <= 1'b1;
            end
            if (state_next == ST_IDLE) begin
                serial_data_oe_n <= 1'b1;
                serial_data_out <= 1'b0;
            end else if (sck_fall && edge_cnt_reg != `SAR_LAST_EDGE) begin
                edge_cnt_reg <= edge_cnt_reg + 5'h01;
                if (edge_cnt_reg == {2'b00, `SAR_ZERO_EDGE} - 5'h01) begin
                    serial_data_oe_n <= 1'b0;
                    serial_data_out <= 1'b0;
                end else if (edge_cnt_reg >= {2'b00, `SAR_ZERO_EDGE}) begin
                    // held until next fall so either host edge works
                    serial_data_out <= shift_reg[15];
                    shift_reg <= {shift_reg[14:0], 1'b0};
                end
            end
        end
    end
endmodule

// >>> verification/sar_readout_sva.sv
module sar_readout_chk (
    input wire clk,
    input wire sys_rst,
    input wire select_n_in,
    input wire serial_clock_in,
    input wire serial_data_out,
    input wire serial_data_oe_n,
    input wire converting,
    input wire powered_down,
    input wire frame_active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    conv_start_a: assert property ($fell(select_n_in) |-> ##[2:5] converting)
        else $error("no conversion");
    frame_open_a: assert property (!select_n_in [*6] |-> frame_active)
        else $error("frame not open");
    oe_late_a: assert property ($fell(select_n_in) |-> serial_data_oe_n [*8])
        else $error("early enable");
    zero_first_a: assert property ($fell(serial_data_oe_n) |-> !serial_data_out)
        else $error("lead bit not zero");
    bit_hold_a: assert property ($changed(serial_data_out) && !serial_data_oe_n |-> $past(!serial_clock_in, 2))
        else $error("bit moved without clock fall");
    idle_power_a: assert property (powered_down != converting)
        else $error("power state wrong");
    conv_len_a: assert property ($rose(converting) |-> converting [*8] ##[6:10] !converting)
        else $error("conversion length");
    release_out_a: assert property ($rose(select_n_in) |-> ##[1:6] serial_data_oe_n)
        else $error("output not released");
endmodule

bind sar_readout sar_readout_chk chk (.*);

// >>> verification/sar_host_model.sv
module sar_host_model (
    output reg select_n,
    output reg sck,
    input wire sdo,
    input wire oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        select_n = 1'b1;
        sck = 1'b1;
    end
    // clock stands high between frames; a released pin reads inverted
    task frame(output [16:0] got);
        integer i;
        got = 17'h0;
        #7;
        select_n = 1'b0;
        #300;
        for (i = 1; i <= 22; i = i + 1) begin
            #100;
            if (i >= 6) got = {got[15:0], oe_n ? ~sdo : sdo};
            if (i <= 21) sck = 1'b0;
            #100;
            sck = 1'b1;
        end
        select_n = 1'b1;
        #400;
    endtask
endmodule

// >>> verification/sar_readout_tb.sv
module sar_readout_tb;
    timeunit 1ns;
    timeprecision 1ps;
    reg clk = 1'b0;
    reg sys_rst = 1'b1;
    reg sample_valid = 1'b0;
    reg sample_over = 1'b0;
    reg sample_under = 1'b0;
    reg [15:0] sample_code = 16'h0000;
    wire sample_ready, select_n, sck, sdo, oe_n;
    integer failures = 0;
    integer checked = 0;
    sar_readout dut (.clk(clk), .sys_rst(sys_rst), .select_n_in(select_n), .serial_clock_in(sck),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_code(sample_code),
        .sample_over(sample_over), .sample_under(sample_under), .serial_data_out(sdo),
        .serial_data_oe_n(oe_n), .converting(), .powered_down(), .frame_active());
    sar_host_model host (.select_n(select_n), .sck(sck), .sdo(sdo), .oe_n(oe_n));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task give_verdict;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input [16:0] got, input [16:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task push(input [15:0] code, input over, input under);
        integer n;
        reg rdy;
        n = 0;
        rdy = 1'b0;
        @(posedge clk);
        sample_valid <= 1'b1;
        sample_code <= code;
        sample_over <= over;
        sample_under <= under;
        // ready is taken settled before the edge at which the write lands
        do begin
            @(negedge clk);
            rdy = sample_ready;
            @(posedge clk);
            n = n + 1;
        end while (rdy !== 1'b1 && n < 40);
        sample_valid <= 1'b0;
        if (n >= 40) begin
            failures = failures + 1;
            give_verdict;
        end
    endtask
    task one(input [15:0] code, input over, input under, input [15:0] exp);
        reg [16:0] g;
        push(code, over, under);
        host.frame(g);
        chk(g, {1'b0, exp});
    endtask
    task t_fill;
        reg [16:0] g;
        reg [15:0] c;
        integer i;
        c = 16'h0000;
        for (i = 0; i < 16; i = i + 1) begin
            push(c, 1'b0, 1'b0);
            c = c + 16'h1111;
        end
        @(posedge clk);
        chk({16'h0000, sample_ready}, 17'h00000);
        c = 16'h0000;
        for (i = 0; i < 16; i = i + 1) begin
            host.frame(g);
            chk(g, {1'b0, c});
            c = c + 16'h1111;
        end
        $display("fill done");
    endtask
    task t_sat;
        one(16'h1234, 1'b1, 1'b0, 16'hFFFF);
        one(16'h1234, 1'b0, 1'b1, 16'h0000);
        one(16'h8001, 1'b1, 1'b1, 16'hFFFF);
        one(16'h7FFF, 1'b0, 1'b0, 16'h7FFF);
        $display("saturation done");
    endtask
    task t_live;
        reg [16:0] g;
        fork
            host.frame(g);
            push(16'hC3A5, 1'b0, 1'b0);
        join
        chk(g, 17'h0C3A5);
        $display("live sample done");
    endtask
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_fill;
        t_sat;
        t_live;
        give_verdict;
    end
endmodule
